/* rtl/phy_error_counters_led_select.sv */
`timescale 1ns/100ps
`default_nettype none
`include "phy_err_params.svh"

// Operation
// - False carrier count fills 16 bits, read only, cleared by reading.
// - Disconnect counter advances one per receive disconnect event.
// - All counters stop at all ones and clear after a read.
// - Receive error frame counter advances at most once per errored frame.
// - Symbol error counter advances on invalid received symbols.
// - One count per run of up to six consecutive bad symbols, taken on its first.
// - Premature end of frame counter advances once per premature termination.
// - 10 Mb end of frame error counter advances once per event.
// - Jabber counter advances per jabber event; resets to one.
// - Equalizer register is 16-bit read-write storage without function.
// - LED control bits 15:3 are stored read-write with no function.
// - Bank answers as management registers 16 through 31.
// - Only management accesses to PHY address 00001b are answered.
module phy_error_counters_led_select
    import phy_err_pkg::*;
#(
    // Bad symbols folded into one count; at most 8 fit the 3-bit run counter
    parameter int SYM_RUN_LEN = `SYM_RUN_LEN
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic mgmt_rd_in,
    input wire logic mgmt_wr_in,
    input wire logic [4:0] mgmt_phy_addr_in,
    input wire logic [4:0] mgmt_reg_addr_in,
    input wire logic [15:0] mgmt_wdata_in,
    output logic [15:0] mgmt_rdata_out,
    output logic mgmt_ack_out,
    input wire logic false_carrier_evt_in,
    input wire logic disconnect_evt_in,
    input wire logic symbol_strobe_in,
    input wire logic symbol_bad_in,
    input wire logic frame_end_in,
    input wire logic premature_eof_evt_in,
    input wire logic eof_err_10m_evt_in,
    input wire logic jabber_evt_in,
    input wire logic activity_in,
    input wire logic speed_in,
    input wire logic link_in,
    input wire logic collision_in,
    output logic activity_indicator_output_out,
    output logic link_indicator_output_out
);

    // =====================================================
    // Decode helpers

    function automatic logic is_reg(
        input logic [4:0] addr,
        input logic [4:0] reg_no
    );
        is_reg = (addr == reg_no);
    endfunction

    function automatic logic is_cnt(
        input logic [4:0] addr,
        input logic [`CNT_IDX_W-1:0] idx
    );
        logic [4:0] num;
        // Counters sit at consecutive numbers from the false carrier count
        num = `REG_FALSE_CARRIER + {2'h0, idx};
        is_cnt = (addr == num);
    endfunction

    // Saturating count; a clear that meets an event keeps the event
    function automatic word_t bump(
        input word_t cur,
        input logic inc,
        input logic clr
    );
        word_t nxt;
        // A full counter holds at all ones until a read clears it
        nxt = cur;
        if (clr) begin
            nxt = inc ? word_t'(1) : `CNT_RST;
        end else if (inc && (cur != '1)) begin
            nxt = cur + word_t'(1);
        end
        bump = nxt;
    endfunction

    // =====================================================
    // State

    // Jabber counter leaves reset at one, the others at zero
    localparam state_s ST_RST = '{
        cnt: {`JABBER_RST, `CNT_RST, `CNT_RST, `CNT_RST,
              `CNT_RST, `CNT_RST, `CNT_RST},
        eq_reg: `EQ_RST,
        led_ctrl: `LED_CTRL_RST,
        sym_run: '0,
        err_pend: 1'b0,
        rdata: '0,
        ack: 1'b0,
        act_led: 1'b0,
        link_led: 1'b0
    };

    state_s s_q;
    state_s s_d;

    // Last position of a bad-symbol run, where the run counter wraps
    localparam logic [`SYM_RUN_W-1:0] RUN_LAST = `SYM_RUN_W'(SYM_RUN_LEN - 1);

    // Requests are one-cycle strobes; the answer flops raise ack a cycle later
    logic addr_hit;
    logic rd_hit;
    logic wr_hit;
    logic bad_sym;
    logic sym_inc;
    logic frame_close;
    logic err_cause;
    logic frame_inc;
    logic [`CNT_NUM-1:0] evt;
    // Per-counter read strobes, shared by the clear and the read mux
    logic [`CNT_NUM-1:0] rd_clr;
    logic [`LED_SEL_MSB:`LED_SEL_LSB] led_sel;

    // =====================================================
    // Next state

    always_comb begin
        s_d = s_q;

        // =====================================================
        // Access decode

        addr_hit = (mgmt_phy_addr_in == `PHY_OWN_ADDR)
                && mgmt_reg_addr_in[`BANK_SEL_BIT];
        rd_hit = mgmt_rd_in && addr_hit;
        // Read wins when both strobes meet; the write is dropped
        wr_hit = mgmt_wr_in && addr_hit && !mgmt_rd_in;
        s_d.ack = rd_hit || wr_hit;

        // =====================================================
        // Symbol runs and error frames

        bad_sym = symbol_strobe_in && symbol_bad_in;
        sym_inc = 1'b0;
        frame_close = frame_end_in || premature_eof_evt_in;

        if (bad_sym) begin
            sym_inc = (s_q.sym_run == '0);
            if (s_q.sym_run == RUN_LAST) begin
                s_d.sym_run = '0;
            end else begin
                s_d.sym_run = s_q.sym_run + `SYM_RUN_W'(1);
            end
        end else if (symbol_strobe_in) begin
            s_d.sym_run = '0;
        end
        if (frame_close) begin
            s_d.sym_run = '0;
        end

        // once per errored frame
        // A pending flag carries the error to the frame close, so many errors
        // in one frame still add one; a close with a fresh error counts it too
        err_cause = bad_sym || premature_eof_evt_in;
        frame_inc = 1'b0;
        if (frame_close) begin
            frame_inc = s_q.err_pend || err_cause;
            s_d.err_pend = 1'b0;
        end else if (err_cause) begin
            s_d.err_pend = 1'b1;
        end

        // =====================================================
        // Counter bank

        evt[`IDX_FALSE_CARRIER] = false_carrier_evt_in;
        evt[`IDX_DISCONNECT] = disconnect_evt_in;
        evt[`IDX_RX_ERR_FRAME] = frame_inc;
        evt[`IDX_SYMBOL_ERR] = sym_inc;
        evt[`IDX_PREMATURE_EOF] = premature_eof_evt_in;
        // 10 Mb end of frame errors
        evt[`IDX_EOF_ERR_10M] = eof_err_10m_evt_in;
        evt[`IDX_JABBER] = jabber_evt_in;

        for (int i = 0; i < `CNT_NUM; i++) begin
            rd_clr[i] = rd_hit && is_cnt(mgmt_reg_addr_in, `CNT_IDX_W'(i));
        end

        for (int i = 0; i < `CNT_NUM; i++) begin
            s_d.cnt[i] = bump(s_q.cnt[i], evt[i], rd_clr[i]);
        end

        // =====================================================
        // Register access

        // Read data holds the value seen before the clear
        if (rd_hit) begin
            // Unused numbers in the bank answer with zero
            s_d.rdata = '0;
            for (int i = 0; i < `CNT_NUM; i++) begin
                if (rd_clr[i]) begin
                    s_d.rdata = s_q.cnt[i];
                end
            end
            if (is_reg(mgmt_reg_addr_in, `REG_EQUALIZER)) begin
                s_d.rdata = s_q.eq_reg;
            end
            if (is_reg(mgmt_reg_addr_in, `REG_LED_SELECT)) begin
                s_d.rdata = s_q.led_ctrl;
            end
        end

        // Counter writes are dropped; they are read only
        if (wr_hit) begin
            if (is_reg(mgmt_reg_addr_in, `REG_EQUALIZER)) begin
                s_d.eq_reg = mgmt_wdata_in;
            end
            if (is_reg(mgmt_reg_addr_in, `REG_LED_SELECT)) begin
                s_d.led_ctrl = mgmt_wdata_in;
            end
        end

        // =====================================================
        // LED drive

        led_sel = s_q.led_ctrl[`LED_SEL_MSB:`LED_SEL_LSB];
        case (led_sel)
            // Codes 000 to 011 pass live sources, sampled here so the pins lag a cycle
            3'h0: begin
                s_d.act_led = activity_in;
                s_d.link_led = link_in;
            end
            3'h1: begin
                s_d.act_led = speed_in;
                s_d.link_led = collision_in;
            end
            3'h2: begin
                s_d.act_led = speed_in;
                s_d.link_led = link_in;
            end
            3'h3: begin
                s_d.act_led = activity_in;
                s_d.link_led = collision_in;
            end
            // Codes 100 to 111 force the pins: bit 1 the first, bit 0 the second
            3'h4: begin
                s_d.act_led = 1'b0;
                s_d.link_led = 1'b0;
            end
            3'h5: begin
                s_d.act_led = 1'b0;
                s_d.link_led = 1'b1;
            end
            3'h6: begin
                s_d.act_led = 1'b1;
                s_d.link_led = 1'b0;
            end
            default: begin
                s_d.act_led = 1'b1;
                s_d.link_led = 1'b1;
            end
        endcase
    end

    // =====================================================
    // Registers

    // The reset branch loads only the constant image
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================
    // Outputs

    // Every output comes from a flop, so an LED never glitches on a select change
    assign mgmt_rdata_out = s_q.rdata;
    assign mgmt_ack_out = s_q.ack;
    assign activity_indicator_output_out = s_q.act_led;
    assign link_indicator_output_out = s_q.link_led;

endmodule // phy_error_counters_led_select

`default_nettype wire

/* rtl/phy_err_params.svh */
`ifndef PHY_ERR_PARAMS_SVH
`define PHY_ERR_PARAMS_SVH

// =====================================================
// Management addressing
`define PHY_OWN_ADDR 5'h01
`define BANK_SEL_BIT 4

// =====================================================
// Register numbers
`define REG_FALSE_CARRIER 5'h13
`define REG_DISCONNECT 5'h14
`define REG_RX_ERR_FRAME 5'h15
`define REG_SYMBOL_ERR 5'h16
`define REG_PREMATURE_EOF 5'h17
`define REG_EOF_ERR_10M 5'h18
`define REG_JABBER 5'h19
`define REG_EQUALIZER 5'h1A
`define REG_LED_SELECT 5'h1B

// =====================================================
// Counter bank layout
`define CNT_W 16
`define CNT_NUM 7
`define CNT_IDX_W 3
`define IDX_FALSE_CARRIER 3'h0
`define IDX_DISCONNECT 3'h1
`define IDX_RX_ERR_FRAME 3'h2
`define IDX_SYMBOL_ERR 3'h3
`define IDX_PREMATURE_EOF 3'h4
`define IDX_EOF_ERR_10M 3'h5
`define IDX_JABBER 3'h6

// =====================================================
// Reset values and fields
`define CNT_RST 16'h0000
`define JABBER_RST 16'h0001
`define EQ_RST 16'h0000
`define LED_CTRL_RST 16'h0000
`define LED_SEL_MSB 2
`define LED_SEL_LSB 0

// =====================================================
// Symbol run grouping
`define SYM_RUN_W 3
`define SYM_RUN_LEN 32'h6

`endif

/* rtl/phy_err_pkg.sv */
`include "phy_err_params.svh"

package phy_err_pkg;

    typedef logic [`CNT_W-1:0] word_t;

    typedef struct packed {
        logic [`CNT_NUM-1:0][`CNT_W-1:0] cnt;
        word_t eq_reg;
        word_t led_ctrl;
        logic [`SYM_RUN_W-1:0] sym_run;
        logic err_pend;
        word_t rdata;
        logic ack;
        logic act_led;
        logic link_led;
    } state_s;

endpackage

/* sim/phy_err_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module phy_err_chk (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic mgmt_rd_in,
    input wire logic mgmt_wr_in,
    input wire logic [4:0] mgmt_phy_addr_in,
    input wire logic [4:0] mgmt_reg_addr_in,
    input wire logic [15:0] mgmt_wdata_in,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic mgmt_ack_out,
    input wire logic false_carrier_evt_in,
    input wire logic activity_in,
    input wire logic speed_in,
    input wire logic link_in,
    input wire logic collision_in,
    input wire logic activity_indicator_output_out,
    input wire logic link_indicator_output_out
);
    // ==========
    // Decoded accesses
    wire logic [4:0] r = mgmt_reg_addr_in;
    wire logic [15:0] q = mgmt_rdata_out;
    wire logic hit = (mgmt_rd_in | mgmt_wr_in) & (mgmt_phy_addr_in == 5'h01) & r[4];
    wire logic rk = hit & mgmt_rd_in;
    wire logic wk = hit & !mgmt_rd_in;
    logic [2:0] sel_q;
    // Shadow of the select field, so the LED checks need no internals
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_q <= 3'h0;
        end else if (wk && r == 5'h1B) begin
            sel_q <= mgmt_wdata_in[2:0];
        end
    end
    wire logic e_act = sel_q[2] ? sel_q[1] : (^sel_q[1:0] ? speed_in : activity_in);
    wire logic e_lnk = sel_q[2] ? sel_q[0] : (sel_q[0] ? collision_in : link_in);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    chk_ack_taken: assert property (hit |=> mgmt_ack_out)
        else $error("access not acknowledged");
    chk_ack_refused: assert property (!hit |=> !mgmt_ack_out)
        else $error("acknowledge without a valid access");
    chk_rdata_held: assert property (!mgmt_ack_out |-> $stable(q))
        else $error("read data moved without a read");
    chk_read_clears: assert property (
        (rk && r == 5'h13 && !false_carrier_evt_in) [*2] |=> q == 16'h0000)
        else $error("counter not cleared by read");
    chk_eq_stores: assert property (
        (wk && r == 5'h1A) ##1 (rk && r == 5'h1A) |=> q == $past(mgmt_wdata_in, 2))
        else $error("equalizer word not stored");
    chk_led_spare: assert property (
        (wk && r == 5'h1B) ##1 (rk && r == 5'h1B) |=> q == $past(mgmt_wdata_in, 2))
        else $error("LED control word not stored");
    chk_led_first: assert property (
        1'b1 |=> activity_indicator_output_out == $past(e_act))
        else $error("first LED source wrong");
    chk_led_second: assert property (
        1'b1 |=> link_indicator_output_out == $past(e_lnk))
        else $error("second LED source wrong");
    cover property (rk && r == 5'h16);
    cover property (wk && r == 5'h1B);
    cover property ((mgmt_rd_in | mgmt_wr_in) && !hit);
endmodule // phy_err_chk
`default_nettype wire

/* sim/mgmt_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mgmt_ctrl_model (
    input wire logic mclk_in,
    input wire logic ack_in,
    input wire logic [15:0] rdata_in,
    output logic rd_out,
    output logic wr_out,
    output logic [4:0] pa_out,
    output logic [4:0] ra_out,
    output logic [15:0] wd_out
);
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        pa_out = 5'h01;
        ra_out = 5'h00;
        wd_out = 16'h0000;
    end
    // ==========
    // One word access; call just after a falling edge
    // numbered register at the PHY address
    task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic ok, output logic [15:0] rq);
        rd_out = rd;
        wr_out = !rd;
        pa_out = pa;
        ra_out = ra;
        wd_out = wd;
        @(posedge mclk_in);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // Released data must not look valid
        wd_out <= ~wd;
        @(negedge mclk_in);
        ok = ack_in;
        rq = rdata_in;
    endtask
endmodule // mgmt_ctrl_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic rd, wr, ack, act_o, lnk_o, ok;
    logic [4:0] pa, ra;
    logic [15:0] wd, rdat, q;
    logic [7:0] ev = 8'h00;
    logic [3:0] src = 4'h0;
    logic [5:0] lv;
    int n_errors = 0;
    int n_tests = 0;
    int a_sel[8] = '{3, 2, 2, 3, 4, 4, 5, 5};
    int l_sel[8] = '{1, 0, 1, 0, 4, 5, 4, 5};
    int evb[4] = '{0, 1, 6, 7};
    int evr[4] = '{19, 20, 24, 25};
    always #5 mclk_in = ~mclk_in;
    phy_error_counters_led_select DUT (.mclk_in, .rst_in, .mgmt_rd_in(rd), .mgmt_wr_in(wr),
        .mgmt_phy_addr_in(pa), .mgmt_reg_addr_in(ra), .mgmt_wdata_in(wd),
        .mgmt_rdata_out(rdat), .mgmt_ack_out(ack), .false_carrier_evt_in(ev[0]),
        .disconnect_evt_in(ev[1]), .symbol_strobe_in(ev[2]), .symbol_bad_in(ev[3]),
        .frame_end_in(ev[4]), .premature_eof_evt_in(ev[5]), .eof_err_10m_evt_in(ev[6]),
        .jabber_evt_in(ev[7]), .activity_in(src[3]), .speed_in(src[2]), .link_in(src[1]),
        .collision_in(src[0]), .activity_indicator_output_out(act_o),
        .link_indicator_output_out(lnk_o));
    mgmt_ctrl_model m (.mclk_in, .ack_in(ack), .rdata_in(rdat), .rd_out(rd), .wr_out(wr),
        .pa_out(pa), .ra_out(ra), .wd_out(wd));
    // ==========
    // Shared tasks
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input int r, input logic [15:0] exp);
        m.xfer(1'b1, 5'h01, 5'(r), 16'h0000, ok, q);
        check("ack", {15'h0000, ok}, 16'h0001);
        check("rdata", q, exp);
    endtask
    // Event held high for n edges, then one quiet cycle
    task automatic pulse(input int b, input int n);
        ev[b] = 1'b1;
        repeat (n) @(negedge mclk_in);
        ev[b] = 1'b0;
        @(negedge mclk_in);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========
    // Tests
    initial begin
        repeat (10) @(negedge mclk_in);
        rst_in = 1'b0;
        for (int r = 19; r < 26; r++) rdchk(r, (r == 25) ? 16'h0001 : 16'h0000);
        foreach (evb[i]) begin
            pulse(evb[i], 3);
            rdchk(evr[i], 16'h0003);
            rdchk(evr[i], 16'h0000);
        end
        ev[3] = 1'b1;
        pulse(2, 13);
        ev[3] = 1'b0;
        pulse(2, 1);
        ev[3] = 1'b1;
        pulse(2, 1);
        ev[3] = 1'b0;
        pulse(4, 1);
        pulse(4, 1);
        pulse(5, 1);
        rdchk(22, 16'h0004);
        rdchk(21, 16'h0002);
        rdchk(23, 16'h0001);
        pulse(1, 65537);
        rdchk(20, 16'hFFFF);
        pulse(0, 2);
        m.xfer(1'b1, 5'h02, 5'h13, 16'h0000, ok, q);
        check("foreign", {15'h0000, ok}, 16'h0000);
        m.xfer(1'b1, 5'h01, 5'h05, 16'h0000, ok, q);
        check("low reg", {15'h0000, ok}, 16'h0000);
        rdchk(19, 16'h0002);
        rdchk(19, 16'h0000);
        m.xfer(1'b0, 5'h01, 5'h1A, 16'hA5C3, ok, q);
        rdchk(26, 16'hA5C3);
        m.xfer(1'b0, 5'h01, 5'h1B, 16'h0006, ok, q);
        rdchk(27, 16'h0006);
        rdchk(28, 16'h0000);
        for (int s = 0; s < 16; s++) begin
            m.xfer(1'b0, 5'h01, 5'h1B, {13'h0000, s[2:0]}, ok, q);
            src = s[3] ? 4'hA : 4'h5;
            lv = {2'b10, src};
            repeat (2) @(negedge mclk_in);
            check("led1", {15'h0000, act_o}, {15'h0000, lv[a_sel[s[2:0]]]});
            check("led2", {15'h0000, lnk_o}, {15'h0000, lv[l_sel[s[2:0]]]});
        end
        end_of_test();
    end
    // Whole run is about 66k cycles
    initial begin
        #1000000;
        n_errors++;
        end_of_test();
    end
endmodule // tb
bind phy_error_counters_led_select phy_err_chk u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .mgmt_rd_in(mgmt_rd_in), .mgmt_wr_in(mgmt_wr_in),
    .mgmt_phy_addr_in(mgmt_phy_addr_in), .mgmt_reg_addr_in(mgmt_reg_addr_in),
    .mgmt_wdata_in(mgmt_wdata_in), .mgmt_rdata_out(mgmt_rdata_out),
    .mgmt_ack_out(mgmt_ack_out), .false_carrier_evt_in(false_carrier_evt_in),
    .activity_in(activity_in), .speed_in(speed_in), .link_in(link_in),
    .collision_in(collision_in),
    .activity_indicator_output_out(activity_indicator_output_out),
    .link_indicator_output_out(link_indicator_output_out));
`default_nettype wire
